// File: rtl/hwsb_bank.sv
// Behaviour
// - Bit 2 of the voltage compare status is set when the analog supply reading crosses its limit.
// - Bit 1 of the voltage compare status is set when the second voltage input crosses its limit.
// - Bit 0 of the voltage compare status is set when the first voltage input crosses its limit; bits 7 to 3 read 0.
// - Reading the supply interrupt status returns the latched flags then clears them.
// - Supply interrupt status bit 1 latches when the battery reading leaves its high/low window.
// - Supply interrupt status bit 0 latches when the standby reading leaves its window; bits 7 to 2 read 0.
// - A one in mask bit 4, 1 or 0 keeps the matching source from raising the management interrupt.
// - The processor temperature reads as measured value plus its 8-bit offset register.
// - The auxiliary temperature reads as measured value plus its 8-bit offset register.
// - Real-time bits 7 and 6 read 1 while the matching fan count is over threshold, else 0.
// - Real-time bit 5 sets above over-temperature and clears only once below hysteresis.
// - Real-time bits 3 to 0 read 1 while the supply is outside its window; bit 4 reads 0.
`timescale 1ns/100ps
`default_nettype none
`include "hwsb_map.svh"

module hwsb_bank (
  input  wire logic                    i_core_clk,
  input  wire logic                    i_reset,
  input  wire hwsb_pkg::hwsb_bus_req_t i_bus,
  output logic [7:0]                   o_rdata,
  input  wire hwsb_pkg::hwsb_events_t  i_events,
  input  wire hwsb_pkg::hwsb_levels_t  i_levels,
  input  wire logic [7:0]              i_processor_temp_raw,
  input  wire logic [7:0]              i_auxiliary_temp_raw,
  output logic                         o_system_management_irq,
  output logic                         o_irq
);

  logic [7:0] vcmp_status;
  logic [7:0] supply_status;
  logic [7:0] supply_mask;
  logic [7:0] cpu_offset;
  logic [7:0] aux_offset;
  logic       temp_status;
  logic       target_three_flag;
  logic [7:0] ev_status;
  logic [7:0] ev_enable;
  logic [7:0] rt_status;
  logic [7:0] ev_set;
  logic       rd_supply;
  logic       rd_vcmp;
  logic       rd_target;

  // Offset add, wraps in eight bits
  function automatic logic [7:0] add_wrap(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[7:0];
  endfunction

  function automatic logic hit(input hwsb_pkg::hwsb_bus_req_t r, input logic [7:0] off);
    return r.addr == off;
  endfunction

  assign rd_supply = i_bus.rd && hit(i_bus, `HWSB_OFF_SUPIRQ);
  assign rd_vcmp   = i_bus.rd && hit(i_bus, `HWSB_OFF_VCMP);
  assign rd_target = rd_supply;

  // Warning flags clear on read; a new crossing wins over the clear
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      vcmp_status <= `HWSB_RST_ZERO;
    end else begin
      if (rd_vcmp) begin
        vcmp_status <= `HWSB_RST_ZERO;
      end
      if (i_events.analog_supply_cross) begin
        vcmp_status[`HWSB_VCMP_ANALOG] <= 1'b1;
      end
      if (i_events.second_input_cross) begin
        vcmp_status[`HWSB_VCMP_SECOND] <= 1'b1;
      end
      if (i_events.first_input_cross) begin
        vcmp_status[`HWSB_VCMP_FIRST] <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      supply_status     <= `HWSB_RST_ZERO;
      target_three_flag <= 1'b0;
    end else begin
      if (rd_supply) begin
        supply_status <= `HWSB_RST_ZERO;
      end
      if (rd_target) begin
        target_three_flag <= 1'b0;
      end
      if (i_events.battery_cross) begin
        supply_status[`HWSB_SUP_BATTERY] <= 1'b1;
      end
      if (i_events.standby_cross) begin
        supply_status[`HWSB_SUP_STANDBY] <= 1'b1;
      end
      if (i_events.target_three_event) begin
        target_three_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      supply_mask <= `HWSB_RST_MASK;
      cpu_offset  <= `HWSB_RST_ZERO;
      aux_offset  <= `HWSB_RST_ZERO;
      ev_enable   <= `HWSB_RST_ZERO;
    end else if (i_bus.wr) begin
      if (hit(i_bus, `HWSB_OFF_SUPMASK)) begin
        supply_mask <= i_bus.wdata & `HWSB_MASK_USED;
      end
      if (hit(i_bus, `HWSB_OFF_CPUOFS)) begin
        cpu_offset <= i_bus.wdata;
      end
      if (hit(i_bus, `HWSB_OFF_AUXOFS)) begin
        aux_offset <= i_bus.wdata;
      end
      if (hit(i_bus, `HWSB_OFF_EVEN)) begin
        ev_enable <= i_bus.wdata & `HWSB_EV_USED;
      end
    end
  end

  // Over-temperature with hysteresis
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      temp_status <= 1'b0;
    end else if (i_levels.temp_above_over) begin
      temp_status <= 1'b1;
    end else if (i_levels.temp_below_hyst) begin
      temp_status <= 1'b0;
    end
  end

  always_comb begin
    rt_status = `HWSB_RST_ZERO;
    rt_status[`HWSB_RT_CPUFAN] = i_levels.processor_fan_over;
    rt_status[`HWSB_RT_SYSFAN] = i_levels.system_fan_over;
    rt_status[`HWSB_RT_PTEMP]  = temp_status;
    rt_status[`HWSB_RT_MAIN]   = i_levels.main_supply_out;
    rt_status[`HWSB_RT_ANALOG] = i_levels.analog_supply_out;
    rt_status[`HWSB_RT_FIRST]  = i_levels.first_input_out;
    rt_status[`HWSB_RT_CORE]   = i_levels.core_voltage_out;
  end

  // Sticky events: bit0 standby, bit1 battery, bit2 analog supply warning
  always_comb begin
    ev_set    = `HWSB_RST_ZERO;
    ev_set[0] = i_events.standby_cross;
    ev_set[1] = i_events.battery_cross;
    ev_set[2] = i_events.analog_supply_cross;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ev_status <= `HWSB_RST_ZERO;
    end else if (i_bus.wr && hit(i_bus, `HWSB_OFF_EVCLR)) begin
      ev_status <= ((ev_status & ~i_bus.wdata) | ev_set) & `HWSB_EV_USED;
    end else begin
      ev_status <= (ev_status | ev_set) & `HWSB_EV_USED;
    end
  end

  assign o_irq = |(ev_status & ev_enable);

  // Management interrupt from unmasked latched sources
  assign o_system_management_irq =
      (supply_status[`HWSB_SUP_STANDBY] & ~supply_mask[`HWSB_SUP_STANDBY]) |
      (supply_status[`HWSB_SUP_BATTERY] & ~supply_mask[`HWSB_SUP_BATTERY]) |
      (target_three_flag & ~supply_mask[`HWSB_MASK_TARGET3]);

  // Read data, one cycle after the strobe
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_rdata <= `HWSB_RST_ZERO;
    end else if (i_bus.rd) begin
      unique case (i_bus.addr)
        `HWSB_OFF_VCMP:    o_rdata <= vcmp_status & `HWSB_VCMP_USED;
        `HWSB_OFF_SUPIRQ:  o_rdata <= supply_status & `HWSB_SUP_USED;
        `HWSB_OFF_SUPMASK: o_rdata <= supply_mask;
        `HWSB_OFF_CPUOFS:  o_rdata <= cpu_offset;
        `HWSB_OFF_AUXOFS:  o_rdata <= aux_offset;
        `HWSB_OFF_RTSTS:   o_rdata <= rt_status & `HWSB_RT_USED;
        `HWSB_OFF_CPUTEMP: o_rdata <= add_wrap(i_processor_temp_raw, cpu_offset);
        `HWSB_OFF_AUXTEMP: o_rdata <= add_wrap(i_auxiliary_temp_raw, aux_offset);
        `HWSB_OFF_EVSTS:   o_rdata <= ev_status;
        `HWSB_OFF_EVEN:    o_rdata <= ev_enable;
        default:           o_rdata <= `HWSB_RST_ZERO;
      endcase
    end else begin
      o_rdata <= `HWSB_RST_ZERO;
    end
  end

endmodule
`default_nettype wire

// File: rtl/hwsb_map.svh
`ifndef HWSB_MAP_SVH
`define HWSB_MAP_SVH

// Register offsets
`define HWSB_OFF_VCMP      8'h42
`define HWSB_OFF_SUPIRQ    8'h50
`define HWSB_OFF_SUPMASK   8'h51
`define HWSB_OFF_CPUOFS    8'h55
`define HWSB_OFF_AUXOFS    8'h56
`define HWSB_OFF_RTSTS     8'h59
`define HWSB_OFF_CPUTEMP   8'h70
`define HWSB_OFF_AUXTEMP   8'h71
`define HWSB_OFF_EVSTS     8'h72
`define HWSB_OFF_EVCLR     8'h73
`define HWSB_OFF_EVEN      8'h74

// Field positions
`define HWSB_VCMP_FIRST    0
`define HWSB_VCMP_SECOND   1
`define HWSB_VCMP_ANALOG   2
`define HWSB_SUP_STANDBY   0
`define HWSB_SUP_BATTERY   1
`define HWSB_MASK_TARGET3  4
`define HWSB_RT_CORE       0
`define HWSB_RT_FIRST      1
`define HWSB_RT_ANALOG     2
`define HWSB_RT_MAIN       3
`define HWSB_RT_PTEMP      5
`define HWSB_RT_SYSFAN     6
`define HWSB_RT_CPUFAN     7

// Used bits of each register
`define HWSB_VCMP_USED     8'h07
`define HWSB_SUP_USED      8'h03
`define HWSB_MASK_USED     8'h13
`define HWSB_RT_USED       8'hEF
`define HWSB_EV_USED       8'h07

// Reset values
`define HWSB_RST_MASK      8'h13
`define HWSB_RST_ZERO      8'h00

`endif

// File: rtl/hwsb_pkg.sv
`default_nettype none
package hwsb_pkg;

  // Limit-comparator events from the monitor datapath
  typedef struct packed {
    logic first_input_cross;
    logic second_input_cross;
    logic analog_supply_cross;
    logic battery_cross;
    logic standby_cross;
    logic target_three_event;
  } hwsb_events_t;

  // Live window/threshold levels
  typedef struct packed {
    logic processor_fan_over;
    logic system_fan_over;
    logic temp_above_over;
    logic temp_below_hyst;
    logic main_supply_out;
    logic analog_supply_out;
    logic first_input_out;
    logic core_voltage_out;
  } hwsb_levels_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } hwsb_bus_req_t;

endpackage
`default_nettype wire

// File: verification/hwsb_bank_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module hwsb_bank_assertions (
  input wire logic                    i_core_clk,
  input wire logic                    i_reset,
  input wire hwsb_pkg::hwsb_bus_req_t i_bus,
  input wire logic [7:0]              o_rdata,
  input wire hwsb_pkg::hwsb_events_t  i_events,
  input wire hwsb_pkg::hwsb_levels_t  i_levels,
  input wire logic                    o_system_management_irq
);
  hwsb_pkg::hwsb_levels_t lv_q;

  always_ff @(posedge i_core_clk) begin
    lv_q <= i_levels;
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);

  sequence s_rd(logic [7:0] a);
    i_bus.rd && i_bus.addr == a;
  endsequence

  a_analog_warn_set: assert property (i_events.analog_supply_cross ##1 s_rd(8'h42) |=> o_rdata[2])
    else $error("analog warn bit missing");
  a_warn_reserved_zero: assert property (s_rd(8'h42) |=> o_rdata[7:3] == 5'h00)
    else $error("warn reserved bits set");
  a_supply_read_clear: assert property (
    (s_rd(8'h50) ##0 !(i_events.battery_cross || i_events.standby_cross)) ##1 s_rd(8'h50) |=> o_rdata == 8'h00)
    else $error("supply flags survived read");
  a_battery_latch: assert property (i_events.battery_cross ##1 s_rd(8'h50) |=> o_rdata[1])
    else $error("battery flag missing");
  a_standby_latch: assert property (i_events.standby_cross ##1 s_rd(8'h50) |=> o_rdata[0] && o_rdata[7:2] == 6'h00)
    else $error("standby flag wrong");
  a_mask_blocks_smi: assert property (
    i_bus.wr && i_bus.addr == 8'h51 && i_bus.wdata[4] && i_bus.wdata[1] && i_bus.wdata[0] |=> !o_system_management_irq)
    else $error("masked source raised irq");
  a_fan_status_live: assert property (s_rd(8'h59) |=> o_rdata[7:6] == {lv_q.processor_fan_over, lv_q.system_fan_over})
    else $error("fan status wrong");
  a_supply_status_live: assert property (s_rd(8'h59) |=> o_rdata[4:0] == {1'b0, lv_q[3:0]})
    else $error("supply status wrong");
  a_overtemp_set: assert property (i_levels.temp_above_over ##1 s_rd(8'h59) |=> o_rdata[5])
    else $error("over-temp bit missing");
endmodule

bind hwsb_bank hwsb_bank_assertions u_chk (.i_core_clk(i_core_clk), .i_reset(i_reset), .i_bus(i_bus),
  .o_rdata(o_rdata), .i_events(i_events), .i_levels(i_levels), .o_system_management_irq(o_system_management_irq));
`default_nettype wire

// File: verification/tb_hwsb_bank.sv
`timescale 1ns/100ps
`default_nettype none
module tb_hwsb_bank;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  hwsb_pkg::hwsb_bus_req_t bus = '0;
  hwsb_pkg::hwsb_events_t  ev = '0;
  hwsb_pkg::hwsb_levels_t  lv = '0;
  logic [7:0]              traw = 8'h00;
  logic [7:0]              araw = 8'h00;
  logic [7:0]              rdata;
  logic                    smi;
  logic                    irq;
  int                      bad_count = 0;
  int                      tests_run = 0;

  always #2.5 clk = ~clk;

  hwsb_bank DUT (.i_core_clk(clk), .i_reset(rst), .i_bus(bus), .o_rdata(rdata), .i_events(ev), .i_levels(lv),
    .i_processor_temp_raw(traw), .i_auxiliary_temp_raw(araw), .o_system_management_irq(smi), .o_irq(irq));

  task automatic close_out;
    if (bad_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // One bus cycle, returning just after the edge that takes it
  task automatic cyc(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
    bus <= '{a, d, w, r};
    @(posedge clk) #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    cyc(a, 8'h00, 1'b0, 1'b1);
    chk(rdata, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(a, d, 1'b1, 1'b0);
  endtask

  task automatic pulse(input hwsb_pkg::hwsb_events_t x);
    ev <= x;
    cyc(8'h00, 8'h00, 1'b0, 1'b0);
    ev <= '0;
  endtask

  task automatic t_reset;
    rd(8'h51, 8'h13);
    rd(8'h55, 8'h00);
    rd(8'h5F, 8'h00);
    chk({6'h00, smi, irq}, 8'h00);
  endtask

  task automatic t_warn;
    logic [5:0] x;
    logic [7:0] e;
    x = 6'h20;
    e = 8'h01;
    for (int i = 0; i < 3; i++) begin
      pulse(x);
      rd(8'h42, e);
      wr(8'h42, 8'hFF);
      rd(8'h42, 8'h00);
      x = x >> 1;
      e = e << 1;
    end
  endtask

  task automatic t_supply;
    wr(8'h51, 8'hFF);
    rd(8'h51, 8'h13);
    pulse(6'h06);
    chk({6'h00, smi, irq}, 8'h00);
    wr(8'h51, 8'h00);
    chk({6'h00, smi, irq}, 8'h02);
    ev <= 6'h06;
    rd(8'h50, 8'h03);
    ev <= '0;
    rd(8'h50, 8'h03);
    rd(8'h50, 8'h00);
    pulse(6'h01);
    chk({6'h00, smi, irq}, 8'h02);
    rd(8'h50, 8'h00);
    chk({6'h00, smi, irq}, 8'h00);
    wr(8'h51, 8'h12);
    pulse(6'h06);
    chk({6'h00, smi, irq}, 8'h02);
    rd(8'h50, 8'h03);
    wr(8'h51, 8'h11);
    pulse(6'h04);
    chk({6'h00, smi, irq}, 8'h02);
    rd(8'h50, 8'h02);
  endtask

  task automatic t_irq;
    wr(8'h73, 8'hFF);
    wr(8'h51, 8'h13);
    wr(8'h74, 8'h01);
    pulse(6'h03);
    chk({6'h00, smi, irq}, 8'h01);
    rd(8'h72, 8'h01);
    wr(8'h74, 8'h00);
    chk({6'h00, smi, irq}, 8'h00);
    wr(8'h74, 8'h01);
    wr(8'h73, 8'h01);
    chk({6'h00, smi, irq}, 8'h00);
    rd(8'h72, 8'h00);
    rd(8'h50, 8'h01);
  endtask

  task automatic t_temp;
    traw <= 8'h20;
    araw <= 8'h7E;
    wr(8'h55, 8'hF0);
    wr(8'h56, 8'h05);
    rd(8'h55, 8'hF0);
    rd(8'h70, 8'h10);
    rd(8'h71, 8'h83);
  endtask

  task automatic t_rt;
    lv <= 8'hDA;
    rd(8'h59, 8'hCA);
    lv <= 8'h20;
    cyc(8'h00, 8'h00, 1'b0, 1'b0);
    rd(8'h59, 8'h20);
    lv <= 8'h00;
    rd(8'h59, 8'h20);
    lv <= 8'h10;
    cyc(8'h00, 8'h00, 1'b0, 1'b0);
    rd(8'h59, 8'h00);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    #1 rst <= 1'b0;
    t_reset();
    t_warn();
    t_supply();
    t_irq();
    t_temp();
    t_rt();
    close_out();
  end

  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    close_out();
  end
endmodule
`default_nettype wire
